//--- src/nested_interrupt_controller.sv
`timescale 1ns/1ps

module nested_interrupt_controller
  import nic_pkg::*;
#(
  parameter int                 NVEC      = NIC_NVEC,
  parameter logic [NIC_NVEC-1:0] HALT_WAKE = NIC_HALT_WAKE
)(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Register port
  input  wire logic [7:0]              regAddr,
  input  wire logic [7:0]              regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic [7:0]                   regRdata,
  // CPU core
  input  wire logic                    instrEnd,
  input  wire logic                    trapExec,
  input  wire nic_pkg::nic_level_load_t returnFromInterrupt,
  input  wire nic_pkg::nic_level_load_t ccSoftLoad,
  input  wire logic                    waitMode,
  input  wire logic                    haltMode,
  output nic_pkg::nic_entry_t          entry,
  output logic [1:0]                   conditionCodeLevel,
  output logic                         wakeup,
  // Sources
  input  wire logic [NIC_GROUPS*NIC_PINS-1:0] extPins,
  input  wire logic [NIC_NVEC-1:0]      periphFlag,
  input  wire logic [NIC_NVEC-1:0]      periphEnable
);
  import nic_pkg::*;

  // Vector count is fixed by the vector table
  if (NVEC != NIC_NVEC || NVEC > NIC_MAXVEC)
  begin : g_chk_nvec
    $error("NVEC must equal the fixed vector table size");
  end
  // Level fields must cover every vector
  if (NIC_LVLREGS * 4 < NVEC || NIC_LVLREGS != 4)
  begin : g_chk_lvl
    $error("Level registers do not cover NVEC");
  end
  // Pin select and pending reads are byte wide
  if (NIC_PINS != 8 || NVEC > 16 || NVEC <= 8)
  begin : g_chk_bytes
    $error("Pin groups and pending reads need byte fields");
  end
  // External groups sit on the lowest vectors
  if (NIC_GROUPS > NVEC || NIC_GROUPS * NIC_SENSE_W > 8)
  begin : g_chk_groups
    $error("Too many external pin groups");
  end
  // Depth counter needs room for all levels
  if (NIC_DEPTH_W < 2)
  begin : g_chk_depth
    $error("Depth counter too narrow");
  end

  localparam int PW = NIC_GROUPS * NIC_PINS;

  typedef struct packed {
    logic [NIC_LVLREGS*8-1:0]        levelBits;
    logic [NIC_GROUPS-1:0][7:0]      pinSel;
    logic [NIC_GROUPS*NIC_SENSE_W-1:0] sense;
    logic                            nestEn;
    logic [PW-1:0]                   pinMeta;
    logic [PW-1:0]                   pinSync;
    logic [NIC_GROUPS-1:0]           nandPrev;
    logic [NIC_GROUPS-1:0]           extLatch;
    logic                            trapPend;
    logic                            resetPend;
    logic                            haltExit;
    logic [NIC_DEPTH_W-1:0]          depth;
    logic [1:0]                      curLevel;
    nic_entry_t                      entry;
    logic                            wake;
    logic [7:0]                      rdata;
  } nic_state_t;

  nic_state_t q;
  nic_state_t d;

  // Level code to ascending rank
  function automatic logic [1:0] nic_rank(input logic [1:0] code);
    logic [1:0] r;
    r = 2'h0;
    case (code)
      NIC_LVL0: r = 2'h0;
      NIC_LVL1: r = 2'h1;
      NIC_LVL2: r = 2'h2;
      NIC_LVL3: r = 2'h3;
      default:  r = 2'h0;
    endcase
    return r;
  endfunction

  logic [NIC_GROUPS-1:0] nandOut;
  logic [NIC_GROUPS-1:0] edgeHit;
  logic [NIC_GROUPS-1:0] levelMode;
  logic [NVEC-1:0]       req;
  logic [NVEC-1:0]       cand;
  logic                  found;
  logic [3:0]            best;
  logic [1:0]            bestRank;
  logic                  waitWake;
  logic                  haltWake;
  logic                  takeMask;
  logic [7:0]            wfield;
  logic [7:0]            oldReg;
  logic [1:0]            sMode;

  always_comb
  begin
    d = q;
    nandOut = '0;
    edgeHit = '0;
    levelMode = '0;
    req = '0;
    cand = '0;
    found = 1'b0;
    best = 4'h0;
    bestRank = 2'h0;
    waitWake = 1'b0;
    haltWake = 1'b0;
    takeMask = 1'b0;
    wfield = 8'h00;
    oldReg = 8'h00;
    sMode = 2'h0;
    d.entry.valid = 1'b0;

    // Pin synchronisers
    d.pinMeta = extPins;
    d.pinSync = q.pinMeta;

    // External groups
    for (int g = 0; g < NIC_GROUPS; g++)
    begin
      // Unselected pins count as high
      nandOut[g] = ~&(q.pinSync[g*NIC_PINS +: NIC_PINS] | ~q.pinSel[g]);
      d.nandPrev[g] = nandOut[g];
      sMode = q.sense[g*NIC_SENSE_W +: NIC_SENSE_W];
      case (sMode)
        NIC_SENSE_FALL: edgeHit[g] = nandOut[g] & ~q.nandPrev[g];
        NIC_SENSE_RISE: edgeHit[g] = ~nandOut[g] & q.nandPrev[g];
        NIC_SENSE_BOTH: edgeHit[g] = nandOut[g] ^ q.nandPrev[g];
        NIC_SENSE_LOW:  levelMode[g] = 1'b1;
        default:        edgeHit[g] = 1'b0;
      endcase
      if (edgeHit[g])
        d.extLatch[g] = 1'b1;
      if (levelMode[g])
        d.extLatch[g] = 1'b0;
      req[g] = levelMode[g] ? nandOut[g] : q.extLatch[g];
    end

    // Peripheral sources, no latch of our own
    for (int i = NIC_GROUPS; i < NVEC; i++)
      req[i] = periphFlag[i] & periphEnable[i];

    // Arbitration, lower index wins ties
    for (int i = NVEC - 1; i >= 0; i--)
    begin
      cand[i] = req[i]
        && (nic_rank(q.levelBits[2*i +: 2]) > nic_rank(q.curLevel))
        && (q.nestEn || q.depth == '0)
        && (!q.haltExit || HALT_WAKE[i]);
      if (cand[i] && (!found || nic_rank(q.levelBits[2*i +: 2]) >= bestRank))
      begin
        found = 1'b1;
        best = 4'(i);
        bestRank = nic_rank(q.levelBits[2*i +: 2]);
      end
    end

    // Wake from low power
    for (int i = 0; i < NVEC; i++)
    begin
      if (req[i] && nic_rank(q.levelBits[2*i +: 2]) > nic_rank(q.curLevel))
      begin
        waitWake = 1'b1;
        if (HALT_WAKE[i])
          haltWake = 1'b1;
      end
    end
    d.wake = (waitMode && (waitWake || q.trapPend))
          || (haltMode && (haltWake || q.trapPend));
    if (haltMode && haltWake)
      d.haltExit = 1'b1;

    // Trap request from the core
    if (trapExec)
      d.trapPend = 1'b1;

    // Level restored by return or set by software
    if (returnFromInterrupt.load)
    begin
      d.curLevel = returnFromInterrupt.level;
      d.depth = q.depth - 1'b1;
    end
    else if (ccSoftLoad.load)
      d.curLevel = ccSoftLoad.level;

    // Service entry
    if (q.resetPend)
    begin
      d.resetPend = 1'b0;
      d.entry.valid = 1'b1;
      d.entry.stack = 1'b0;
      d.entry.vector = NIC_VEC_RESET;
      d.curLevel = NIC_LVL3;
      d.depth = '0;
    end
    else if (instrEnd && !returnFromInterrupt.load && !ccSoftLoad.load)
    begin
      if (q.trapPend)
      begin
        d.trapPend = trapExec;
        d.entry.valid = 1'b1;
        d.entry.stack = 1'b1;
        d.entry.vector = NIC_VEC_TRAP;
        d.curLevel = NIC_LVL3;
        d.depth = q.depth + 1'b1;
      end
      else if (found)
      begin
        takeMask = 1'b1;
        d.entry.valid = 1'b1;
        d.entry.stack = 1'b1;
        d.entry.vector = NIC_VEC_BASE - {11'h000, best, 1'b0};
        d.curLevel = q.levelBits[2*best +: 2];
        d.depth = q.depth + 1'b1;
        d.haltExit = 1'b0;
      end
    end

    // Auto clear of the serviced edge latch only, new edge wins
    for (int g = 0; g < NIC_GROUPS; g++)
    begin
      if (takeMask && best == 4'(g) && !edgeHit[g])
        d.extLatch[g] = 1'b0;
    end

    // Register writes
    if (regWr)
    begin
      case (regAddr)
        NIC_OFS_LEVEL0, NIC_OFS_LEVEL1, NIC_OFS_LEVEL2, NIC_OFS_LEVEL3:
        begin
          oldReg = q.levelBits[8*regAddr[1:0] +: 8];
          wfield = regWdata;
          for (int f = 0; f < 4; f++)
          begin
            if (regWdata[2*f +: 2] == NIC_LVL0)
              wfield[2*f +: 2] = oldReg[2*f +: 2];
          end
          if (regAddr == NIC_OFS_LEVEL3)
            wfield = wfield | NIC_LEVEL3_RO_MASK[7:0];
          d.levelBits[8*regAddr[1:0] +: 8] = wfield;
        end
        NIC_OFS_PINSEL0: d.pinSel[0] = regWdata;
        NIC_OFS_PINSEL1: d.pinSel[1] = regWdata;
        NIC_OFS_SENSE:   d.sense = regWdata[NIC_GROUPS*NIC_SENSE_W-1:0];
        NIC_OFS_CTRL:    d.nestEn = regWdata[NIC_CTRL_NEST_BIT];
        default:         d.nestEn = q.nestEn;
      endcase
    end

    // Register reads
    d.rdata = 8'h00;
    if (regRd)
    begin
      case (regAddr)
        NIC_OFS_LEVEL0:  d.rdata = q.levelBits[7:0];
        NIC_OFS_LEVEL1:  d.rdata = q.levelBits[15:8];
        NIC_OFS_LEVEL2:  d.rdata = q.levelBits[23:16];
        NIC_OFS_LEVEL3:  d.rdata = q.levelBits[31:24];
        NIC_OFS_PINSEL0: d.rdata = q.pinSel[0];
        NIC_OFS_PINSEL1: d.rdata = q.pinSel[1];
        NIC_OFS_SENSE:   d.rdata = {4'h0, q.sense};
        NIC_OFS_CTRL:    d.rdata = {7'h00, q.nestEn};
        NIC_OFS_STATUS:  d.rdata = {3'h0, q.trapPend, q.haltExit, (q.depth != '0), q.curLevel};
        NIC_OFS_PENDLO:  d.rdata = req[7:0];
        NIC_OFS_PENDHI:  d.rdata = {2'h0, req[NVEC-1:8]};
        default:         d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q.levelBits <= {NIC_LVLREGS{NIC_LEVEL_RST}};
      q.pinSel    <= {NIC_GROUPS{NIC_PINSEL_RST}};
      q.sense     <= NIC_SENSE_RST;
      q.nestEn    <= 1'b0;
      q.pinMeta   <= '1;
      q.pinSync   <= '1;
      q.nandPrev  <= '0;
      q.extLatch  <= '0;
      q.trapPend  <= 1'b0;
      q.resetPend <= 1'b1;
      q.haltExit  <= 1'b0;
      q.depth     <= '0;
      q.curLevel  <= NIC_LVL3;
      q.entry     <= '0;
      q.wake      <= 1'b0;
      q.rdata     <= 8'h00;
    end
    else
    begin
      q <= d;
    end
  end

  assign regRdata           = q.rdata;
  assign entry              = q.entry;
  assign conditionCodeLevel = q.curLevel;
  assign wakeup             = q.wake;

endmodule

//--- src/nic_pkg.sv
package nic_pkg;

  // Sizes
  localparam int NIC_NVEC       = 14;
  localparam int NIC_MAXVEC     = 16;
  localparam int NIC_PINS       = 8;
  localparam int NIC_GROUPS     = 2;
  localparam int NIC_LVLREGS    = 4;
  localparam int NIC_DEPTH_W    = 8;

  // Register offsets
  localparam logic [7:0] NIC_OFS_LEVEL0  = 8'h1c;
  localparam logic [7:0] NIC_OFS_LEVEL1  = 8'h1d;
  localparam logic [7:0] NIC_OFS_LEVEL2  = 8'h1e;
  localparam logic [7:0] NIC_OFS_LEVEL3  = 8'h1f;
  localparam logic [7:0] NIC_OFS_PINSEL0 = 8'h20;
  localparam logic [7:0] NIC_OFS_PINSEL1 = 8'h21;
  localparam logic [7:0] NIC_OFS_SENSE   = 8'h22;
  localparam logic [7:0] NIC_OFS_CTRL    = 8'h23;
  localparam logic [7:0] NIC_OFS_STATUS  = 8'h24;
  localparam logic [7:0] NIC_OFS_PENDLO  = 8'h25;
  localparam logic [7:0] NIC_OFS_PENDHI  = 8'h26;

  // Field positions
  localparam int NIC_CTRL_NEST_BIT  = 0;
  localparam int NIC_SENSE_W        = 2;
  localparam int NIC_LEVEL3_RO_MASK = 8'hf0;

  // Reset values
  localparam logic [7:0] NIC_LEVEL_RST  = 8'hff;
  localparam logic [7:0] NIC_PINSEL_RST = 8'h00;
  localparam logic [3:0] NIC_SENSE_RST  = 4'h0;

  // Level codes {high bit, low bit}
  localparam logic [1:0] NIC_LVL0 = 2'h2;
  localparam logic [1:0] NIC_LVL1 = 2'h1;
  localparam logic [1:0] NIC_LVL2 = 2'h0;
  localparam logic [1:0] NIC_LVL3 = 2'h3;

  // Pin sensitivity modes
  localparam logic [1:0] NIC_SENSE_FALL  = 2'h0;
  localparam logic [1:0] NIC_SENSE_RISE  = 2'h1;
  localparam logic [1:0] NIC_SENSE_BOTH  = 2'h2;
  localparam logic [1:0] NIC_SENSE_LOW   = 2'h3;

  // Vector addresses
  localparam logic [15:0] NIC_VEC_RESET = 16'hfffe;
  localparam logic [15:0] NIC_VEC_TRAP  = 16'hfffc;
  localparam logic [15:0] NIC_VEC_BASE  = 16'hfffa;

  // Sources able to end halt
  localparam logic [NIC_NVEC-1:0] NIC_HALT_WAKE = 14'h002b;

  typedef struct packed {
    logic        valid;
    logic        stack;
    logic [15:0] vector;
  } nic_entry_t;

  typedef struct packed {
    logic       load;
    logic [1:0] level;
  } nic_level_load_t;

endpackage

//--- test/nested_interrupt_controller_test.sv
`timescale 1ns/1ps
module nested_interrupt_controller_test;
  import nic_pkg::*;
  logic                clk, sys_rst, regWr, regRd, instrEnd, trapExec, waitMode, haltMode;
  logic                retReq, rdPend, wakeup;
  logic [7:0]          regAddr, regWdata, regRdata;
  logic [1:0]          ccLevel, code;
  logic [15:0]         extPins;
  logic [NIC_NVEC-1:0] periphFlag, periphEnable;
  nic_level_load_t     retLoad, ccSoftLoad;
  nic_entry_t          entry;
  logic [19:0]         entQ[$];
  logic [7:0]          rdQ[$];
  int                  errors, samples_checked, idx;
  nested_interrupt_controller uut (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .instrEnd(instrEnd), .trapExec(trapExec),
    .returnFromInterrupt(retLoad), .ccSoftLoad(ccSoftLoad), .waitMode(waitMode),
    .haltMode(haltMode), .entry(entry), .conditionCodeLevel(ccLevel), .wakeup(wakeup),
    .extPins(extPins), .periphFlag(periphFlag), .periphEnable(periphEnable));
  nic_core_model core (
    .clk(clk), .sys_rst(sys_rst), .entry(entry), .conditionCodeLevel(ccLevel),
    .sleep(waitMode | haltMode), .retReq(retReq), .returnFromInterrupt(retLoad),
    .instrEnd(instrEnd));
  task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rdQ.push_back(exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ret;
    retReq <= 1'b1;
    @(posedge clk);
    retReq <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic settle(input int left);
    repeat (200) if (entQ.size() > left) @(posedge clk);
  endtask
  task automatic expect_ent(input int i, input logic [1:0] lvl);
    entQ.push_back({2'b11, 16'(NIC_VEC_BASE - 2 * i), lvl});
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Entries and read data checked as they appear
  always @(posedge clk)
  begin
    rdPend <= regRd;
    if (rdPend === 1'b1)
      chk("rdata", 20'(regRdata), 20'(rdQ.pop_front()));
    if (entry.valid !== 1'b0)
      chk("entry", {entry, ccLevel}, entQ.size() ? entQ.pop_front() : 20'h0);
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    wrap_up;
  end
  initial
  begin
    sys_rst = 1'b1;
    {regAddr, regWdata, regWr, regRd, trapExec, waitMode, haltMode} = '0;
    {retReq, ccSoftLoad, periphFlag} = '0;
    periphEnable = 14'h3ffc;
    extPins = 16'hffff;
    void'($urandom(40));
    entQ.push_back({2'b10, NIC_VEC_RESET, NIC_LVL3});
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    settle(0);
    for (int k = 0; k < 4; k++)
      rd(8'(NIC_OFS_LEVEL0 + k), NIC_LEVEL_RST);
    wr(NIC_OFS_LEVEL0, 8'hcf);
    wr(NIC_OFS_LEVEL0, 8'h64);
    rd(NIC_OFS_LEVEL0, 8'h44);
    wr(NIC_OFS_LEVEL3, 8'h00);
    rd(NIC_OFS_LEVEL3, 8'hf0);
    rd(8'h40, 8'h00);
    // Pin group 0, falling edges
    wr(NIC_OFS_PINSEL0, 8'h03);
    ccSoftLoad <= {1'b1, NIC_LVL0};
    @(posedge clk);
    ccSoftLoad <= '0;
    expect_ent(0, NIC_LVL2);
    extPins[0] <= 1'b0;
    settle(0);
    ret;
    extPins[1] <= 1'b0;
    repeat (8) @(posedge clk);
    extPins <= 16'hffff;
    // Level beats index, disabled source ignored, loser stays pending
    wr(NIC_OFS_LEVEL1, 8'h0c);
    periphEnable[4] <= 1'b0;
    expect_ent(5, NIC_LVL3);
    expect_ent(3, NIC_LVL1);
    periphFlag <= 14'h0038;
    settle(1);
    periphFlag[5] <= 1'b0;
    ret;
    settle(0);
    periphFlag <= '0;
    periphEnable <= 14'h3ffc;
    ret;
    entQ.push_back({2'b11, NIC_VEC_TRAP, NIC_LVL3});
    trapExec <= 1'b1;
    @(posedge clk);
    trapExec <= 1'b0;
    settle(0);
    ret;
    // Equal levels: lower index first, last vector at bottom of table
    for (int n = 0; n < 6; n++)
    begin
      idx = 2 + $urandom % 11;
      code = ($urandom % 3 == 0) ? NIC_LVL1 : ($urandom % 2) ? NIC_LVL2 : NIC_LVL3;
      for (int k = 0; k < 4; k++)
        wr(8'(NIC_OFS_LEVEL0 + k), {4{code}});
      expect_ent(idx, code);
      expect_ent(13, code);
      periphFlag <= 14'h2000 | (14'h1 << idx);
      settle(1);
      periphFlag[idx] <= 1'b0;
      ret;
      settle(0);
      periphFlag <= '0;
      ret;
    end
    // Halt: only wake-capable sources wake and go first
    wr(NIC_OFS_LEVEL0, 8'h30);
    wr(NIC_OFS_LEVEL1, 8'h04);
    haltMode <= 1'b1;
    @(posedge clk);
    periphFlag <= 14'h0004;
    rd(NIC_OFS_PENDLO, 8'h04);
    repeat (4) @(posedge clk);
    chk("wakeup", 20'(wakeup), 20'h0);
    periphFlag <= 14'h0024;
    repeat (3) @(posedge clk);
    chk("wakeup", 20'(wakeup), 20'h1);
    expect_ent(5, NIC_LVL1);
    expect_ent(2, NIC_LVL3);
    haltMode <= 1'b0;
    settle(1);
    periphFlag[5] <= 1'b0;
    ret;
    settle(0);
    periphFlag <= '0;
    ret;
    // Wait: a non halt-wake source still wakes
    waitMode <= 1'b1;
    @(posedge clk);
    periphFlag <= 14'h0010;
    repeat (3) @(posedge clk);
    chk("wakeup", 20'(wakeup), 20'h1);
    expect_ent(4, NIC_LVL2);
    waitMode <= 1'b0;
    settle(0);
    periphFlag <= '0;
    ret;
    // Nested mode: higher level preempts a running service
    wr(NIC_OFS_CTRL, 8'h01);
    wr(NIC_OFS_LEVEL0, 8'h40);
    wr(NIC_OFS_LEVEL1, 8'h0c);
    expect_ent(3, NIC_LVL1);
    periphFlag <= 14'h0008;
    settle(0);
    expect_ent(5, NIC_LVL3);
    periphFlag <= 14'h0028;
    settle(0);
    periphFlag <= '0;
    ret;
    ret;
    // Group 1 on rising pin edge, group 0 on low level
    wr(NIC_OFS_PINSEL1, 8'h80);
    wr(NIC_OFS_SENSE, 8'h07);
    extPins[15] <= 1'b0;
    repeat (6) @(posedge clk);
    expect_ent(1, NIC_LVL2);
    extPins[15] <= 1'b1;
    settle(0);
    ret;
    expect_ent(0, NIC_LVL2);
    extPins[0] <= 1'b0;
    settle(0);
    extPins[0] <= 1'b1;
    repeat (3) @(posedge clk);
    ret;
    // Group 1 on both pin edges
    wr(NIC_OFS_SENSE, 8'h08);
    for (int k = 0; k < 2; k++)
    begin
      expect_ent(1, NIC_LVL2);
      extPins[15] <= k[0];
      settle(0);
      ret;
    end
    rd(NIC_OFS_SENSE, 8'h08);
    rd(NIC_OFS_CTRL, 8'h01);
    rd(NIC_OFS_STATUS, 8'h02);
    chk("queue", 20'(entQ.size()), 20'h0);
    wrap_up;
  end
endmodule

//--- test/nic_checker.sv
`timescale 1ns/1ps
module nic_checker
  import nic_pkg::*;
#(
  parameter int NVEC = NIC_NVEC
)(
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     sys_rst,
  // Core side
  input wire logic                     instrEnd,
  input wire logic                     trapExec,
  input wire logic                     waitMode,
  input wire logic                     haltMode,
  input wire nic_pkg::nic_level_load_t returnFromInterrupt,
  // Controller outputs
  input wire nic_pkg::nic_entry_t      entry,
  input wire logic [1:0]               conditionCodeLevel,
  input wire logic                     wakeup
);
  logic [1:0] startCnt_q;
  function automatic int rank(input logic [1:0] c);
    return (c == NIC_LVL0) ? 0 : (c == NIC_LVL1) ? 1 : (c == NIC_LVL2) ? 2 : 3;
  endfunction
  // Edges since reset release
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      startCnt_q <= 2'h0;
    else if (startCnt_q != 2'h2)
      startCnt_q <= startCnt_q + 2'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_vector:
    assert property (startCnt_q == 2'h1 |-> entry == {2'h2, NIC_VEC_RESET}
      && conditionCodeLevel == NIC_LVL3) else $error("bad reset entry");
  a_instr_boundary:
    assert property (entry.valid && startCnt_q == 2'h2 |-> $past(instrEnd))
    else $error("entry off boundary");
  a_trap_entry:
    assert property (entry.valid && entry.vector == NIC_VEC_TRAP |-> entry.stack
      && conditionCodeLevel == NIC_LVL3) else $error("bad trap entry");
  a_vector_table:
    assert property (entry.valid && entry.stack && entry.vector != NIC_VEC_TRAP |->
      !entry.vector[0] && entry.vector >= 16'hffe0 && entry.vector <= NIC_VEC_BASE)
    else $error("vector outside table");
  a_level_rises:
    assert property (entry.valid && entry.stack && entry.vector != NIC_VEC_TRAP |->
      rank(conditionCodeLevel) > rank($past(conditionCodeLevel)))
    else $error("entry without higher level");
  a_return_restore:
    assert property (returnFromInterrupt.load |=>
      conditionCodeLevel == $past(returnFromInterrupt.level)) else $error("level not restored");
  a_trap_taken:
    assert property (trapExec |-> ##[1:20] entry.valid && entry.vector == NIC_VEC_TRAP)
    else $error("trap not taken");
  a_wake_cause:
    assert property ($rose(wakeup) |-> $past(waitMode || haltMode))
    else $error("wakeup while running");
  c_trap: cover property (entry.valid && entry.vector == NIC_VEC_TRAP);
  c_nested: cover property (entry.valid && entry.stack ##[1:20] entry.valid && entry.stack);
  c_wake: cover property ($rose(wakeup));
endmodule

bind nested_interrupt_controller nic_checker #(.NVEC(NVEC)) chk (
  .clk(clk), .sys_rst(sys_rst), .instrEnd(instrEnd), .trapExec(trapExec),
  .waitMode(waitMode), .haltMode(haltMode), .returnFromInterrupt(returnFromInterrupt),
  .entry(entry), .conditionCodeLevel(conditionCodeLevel), .wakeup(wakeup));

//--- test/nic_core_model.sv
`timescale 1ns/1ps
module nic_core_model
  import nic_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Controller side
  input  wire nic_pkg::nic_entry_t entry,
  input  wire logic [1:0]          conditionCodeLevel,
  input  wire logic                sleep,
  input  wire logic                retReq,
  output nic_pkg::nic_level_load_t returnFromInterrupt,
  output logic                     instrEnd
);
  logic [1:0] lvlStack[$];
  logic [1:0] prevLvl;
  // One instruction every second cycle, none while asleep
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      instrEnd <= 1'b0;
      returnFromInterrupt <= '0;
      lvlStack.delete();
    end
    else
    begin
      instrEnd <= !sleep && !instrEnd;
      prevLvl <= conditionCodeLevel;
      returnFromInterrupt <= '0;
      if (entry.valid && entry.stack)
        lvlStack.push_back(prevLvl);
      if (retReq && lvlStack.size() > 0)
        returnFromInterrupt <= {1'b1, lvlStack.pop_back()};
    end
endmodule
